/* design/sird_pkg.sv */
// Purpose: Shared constants for the serial interrupt deserializer
// Assumes: One core clock; all pins except the async reset synchronous to it
// Notes:   Frame slots are indexed in the order they arrive
package sird_pkg;
  // Serial packet framing, in core clocks except the frame count
  localparam logic [4:0] START_CLKS   = 5'h08;
  localparam logic [4:0] FRAME_COUNT  = 5'h15;
  localparam logic [4:0] FRAME_PHASES = 5'h03;
  localparam logic [4:0] STOP_QUIET   = 5'h02;
  localparam logic [4:0] STOP_CONT    = 5'h03;
  localparam logic [4:0] GAP_CONT     = 5'h11;
  localparam logic [4:0] BUSY_RISE    = 5'h02;
  // Frame slot positions
  localparam int SLOT_SYS_MGMT = 2;
  localparam int SLOT_IO_CHECK = 16;
  localparam int SLOT_INTA     = 17;
  localparam int SLOT_INTD     = 20;
  // Register port map (word addresses)
  localparam logic [1:0] ADDR_CTRL   = 2'h0;
  localparam logic [1:0] ADDR_FRAMES = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam int CTRL_HOLD_BIT  = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_FRAME = 3'b010,
    ST_STOP  = 3'b011,
    ST_GAP   = 3'b100
  } sird_state_type;
endpackage : sird_pkg

/* design/sird_top.sv */
// Purpose: Serial interrupt line to parallel open-drain interrupt converter
// Assumes: All inputs except RST synchronous to CORE_CLK; pins resolved outside
// Notes:   Open-drain outputs are enables only; the pin pulls low when set
`timescale 1ns/1ps
module sird_top
  import sird_pkg::*;
(
  input  wire logic        CORE_CLK,        // Core clock, 50 MHz
  input  wire logic        RST,             // Async reset, active high
  input  wire logic        DEVICE_RESET_N,  // Device reset, active low
  input  wire logic        SHUTDOWN_N,      // Shutdown, active low
  input  wire logic        POLL_SELECT,     // High continuous, low quiet
  input  wire logic        RECOVERY_DRIVE_SELECT, // Drive high in recovery
  input  wire logic        CYCLE_HOLD_N,    // Low holds off next start
  input  wire logic        SIO_IN,          // Serial line level
  output logic             SIO_OUT,         // Serial line drive value
  output logic             SIO_OE,          // Serial line drive enable
  output logic [20:0]      INT_OE,          // Per-slot pull-low enable
  output logic             BUSY,            // Low while a cycle runs
  output logic             BUSY_OE,         // Busy pin drive enable
  input  wire logic [1:0]  REG_ADDR,        // Register word address
  input  wire logic [31:0] REG_WDATA,       // Register write data
  input  wire logic        REG_WR,          // Write strobe
  input  wire logic        REG_RD,          // Read strobe
  output logic [31:0]      REG_RDATA        // Read data, one cycle later
);

  sird_state_type state_reg, state_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic [4:0]  frame_reg, frame_next;
  logic        mode_reg, mode_next;
  logic        hold_reg, hold_next;
  logic [20:0] slot_reg, slot_next;
  logic [20:0] int_oe_next;
  logic        sio_out_next, sio_oe_next;
  logic        busy_next, busy_oe_next;
  logic        low_seen;
  logic        run;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] rdata_next;
  logic        sw_hold;

  assign run     = DEVICE_RESET_N && SHUTDOWN_N;
  assign sw_hold = ctrl_reg[CTRL_HOLD_BIT];
  assign low_seen = (state_reg == ST_FRAME) && (cnt_reg == 5'h00) && !SIO_IN;

  // Per-slot capture; slot index equals arrival order
  genvar gi;
  generate
    for (gi = 0; gi < 21; gi++)
    begin : g_slot
      always_comb
      begin
        slot_next[gi] = slot_reg[gi];
        if (!DEVICE_RESET_N)
          slot_next[gi] = 1'b0;
        else if (low_seen && SHUTDOWN_N && (frame_reg == 5'(gi)))
          slot_next[gi] = 1'b1;
        else if (!SIO_IN == 1'b0 && SHUTDOWN_N && state_reg == ST_FRAME
                 && cnt_reg == 5'h00 && frame_reg == 5'(gi))
          slot_next[gi] = 1'b0;
        int_oe_next[gi] = run && slot_next[gi];
      end
    end
  endgenerate

  // Sequencer next state
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    frame_next = frame_reg;
    mode_next  = mode_reg;
    hold_next  = hold_reg;
    busy_next  = BUSY;
    if (!DEVICE_RESET_N)
    begin
      state_next = ST_IDLE;
      cnt_next   = 5'h00;
      frame_next = 5'h00;
      mode_next  = 1'b1;
      hold_next  = 1'b0;
      busy_next  = 1'b1;
    end
    else if (SHUTDOWN_N)
    begin
      // Frozen otherwise: shutdown stands in for a stopped clock
      if (state_reg != ST_IDLE && !CYCLE_HOLD_N)
        hold_next = 1'b1;
      case (state_reg)
        ST_IDLE:
        begin
          busy_next = 1'b1;
          if (POLL_SELECT)
          begin
            state_next = ST_START;
            cnt_next   = 5'h00;
            busy_next  = 1'b0;
          end
          else if (!SIO_IN)
          begin
            // Far end opened the start; we keep it low for the rest
            state_next = ST_START;
            cnt_next   = 5'h01;
            busy_next  = 1'b0;
          end
        end
        ST_START:
        begin
          busy_next = 1'b0;
          cnt_next  = cnt_reg + 5'h01;
          if (cnt_reg == START_CLKS - 5'h01)
          begin
            mode_next  = POLL_SELECT;
            state_next = ST_FRAME;
            cnt_next   = 5'h00;
            frame_next = 5'h00;
          end
        end
        ST_FRAME:
        begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == FRAME_PHASES - 5'h01)
          begin
            cnt_next   = 5'h00;
            frame_next = frame_reg + 5'h01;
            if (frame_reg == FRAME_COUNT - 5'h01)
            begin
              state_next = ST_STOP;
              frame_next = 5'h00;
            end
          end
        end
        ST_STOP:
        begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == (mode_reg ? STOP_CONT : STOP_QUIET) - 5'h01)
          begin
            state_next = ST_GAP;
            cnt_next   = 5'h00;
          end
        end
        ST_GAP:
        begin
          // Gap length tolerated by the far end in any count
          if (cnt_reg != 5'h1F)
            cnt_next = cnt_reg + 5'h01;
          if (!mode_reg)
          begin
            if (cnt_reg == BUSY_RISE - 5'h01)
            begin
              busy_next  = 1'b1;
              state_next = ST_IDLE;
              hold_next  = 1'b0;
            end
          end
          else
          begin
            busy_next = 1'b1;
            if (cnt_reg >= GAP_CONT - 5'h01)
            begin
              if (!POLL_SELECT)
              begin
                state_next = ST_IDLE;
                hold_next  = 1'b0;
              end
              else if (!hold_reg && CYCLE_HOLD_N && !sw_hold)
              begin
                state_next = ST_START;
                cnt_next   = 5'h00;
                busy_next  = 1'b0;
                hold_next  = 1'b0;
              end
              else if (hold_reg && CYCLE_HOLD_N)
                hold_next = 1'b0;
            end
          end
        end
        default:
          state_next = ST_IDLE;
      endcase
    end
  end

  // Line drive follows the next state so pins line up with it
  always_comb
  begin
    sio_oe_next  = 1'b0;
    sio_out_next = 1'b1;
    busy_oe_next = run;
    if (run && (state_next == ST_START || state_next == ST_STOP))
    begin
      sio_oe_next  = 1'b1;
      sio_out_next = 1'b0;
    end
    else if (run && low_seen)
    begin
      sio_oe_next  = RECOVERY_DRIVE_SELECT;
      sio_out_next = 1'b1;
    end
  end

  // Register port: control write, frame and status reads
  always_comb
  begin
    ctrl_next  = ctrl_reg;
    rdata_next = 32'h0000_0000;
    if (REG_WR && REG_ADDR == ADDR_CTRL)
      ctrl_next = {31'h0000_0000, REG_WDATA[CTRL_HOLD_BIT]};
    if (REG_RD)
    begin
      case (REG_ADDR)
        ADDR_CTRL:   rdata_next = ctrl_reg;
        ADDR_FRAMES: rdata_next = {11'h000, slot_reg};
        ADDR_STATUS: rdata_next = {25'h0000000, hold_reg, mode_reg, BUSY, state_reg, 1'b0};
        default:     rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // State registers
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= ST_IDLE;   // Idle first, so the start gets all eight driven clocks
      cnt_reg   <= 5'h00;
      frame_reg <= 5'h00;
      mode_reg  <= 1'b1;
      hold_reg  <= 1'b0;
      slot_reg  <= 21'h000000;
      INT_OE    <= 21'h000000;
      SIO_OUT   <= 1'b1;
      SIO_OE    <= 1'b0;
      BUSY      <= 1'b1;
      BUSY_OE   <= 1'b0;
      ctrl_reg  <= CTRL_RESET;
      REG_RDATA <= 32'h0000_0000;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      frame_reg <= frame_next;
      mode_reg  <= mode_next;
      hold_reg  <= hold_next;
      slot_reg  <= slot_next;
      INT_OE    <= int_oe_next;
      SIO_OUT   <= sio_out_next;
      SIO_OE    <= sio_oe_next;
      BUSY      <= busy_next;
      BUSY_OE   <= busy_oe_next;
      ctrl_reg  <= ctrl_next;
      REG_RDATA <= rdata_next;
    end
  end

  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST || !DEVICE_RESET_N || !SHUTDOWN_N);

  sequence start_from_zero_s;
    state_reg == ST_START && cnt_reg == 5'h00;
  endsequence
  sequence start_body_s;
    (state_reg == ST_START && SIO_OE && !SIO_OUT)[*8] ##1 state_reg == ST_FRAME;
  endsequence

  start_len_a: assert property (start_from_zero_s |-> start_body_s)
    else $error("start frame not eight clocks low");
  frame_cnt_a: assert property ($rose(state_reg == ST_FRAME) |->
      ##62 state_reg == ST_FRAME ##1 state_reg == ST_STOP)
    else $error("frame count not 21");
  stop_cont_a: assert property ($rose(state_reg == ST_STOP) && mode_reg |->
      (state_reg == ST_STOP && SIO_OE && !SIO_OUT)[*3] ##1 state_reg != ST_STOP)
    else $error("continuous stop not three clocks");
  stop_quiet_a: assert property ($rose(state_reg == ST_STOP) && !mode_reg |->
      (state_reg == ST_STOP)[*2] ##1 state_reg != ST_STOP)
    else $error("quiet stop not two clocks");
  gap_cont_a: assert property ($fell(state_reg == ST_STOP) && mode_reg |->
      (state_reg == ST_GAP)[*8] ##1 (state_reg == ST_GAP)[*8] ##1 state_reg == ST_GAP)
    else $error("continuous gap shorter than 17");
  mode_hold_a: assert property (state_reg == ST_FRAME |=> $stable(mode_reg))
    else $error("mode changed after start frame");
  busy_low_a: assert property (state_reg == ST_IDLE && !POLL_SELECT && !SIO_IN |=>
      !BUSY)
    else $error("busy not low one clock after start");
  busy_rise_a: assert property ($fell(state_reg == ST_STOP) && !mode_reg |->
      !BUSY ##1 !BUSY ##1 BUSY)
    else $error("busy not high two clocks after stop");
  recov_drv_a: assert property (low_seen |=> SIO_OE == $past(RECOVERY_DRIVE_SELECT)
      && SIO_OUT)
    else $error("recovery drive wrong");
  slot_set_a: assert property (low_seen |=> ##1 INT_OE[$past(frame_reg, 2)])
    else $error("slot not asserted after low sample");

  // Mode entry, start ownership, hold and float checks
  sequence drive_start_s;
    state_reg == ST_START && SIO_OE && !SIO_OUT;
  endsequence

  cont_start_a: assert property (state_reg == ST_IDLE && POLL_SELECT |=>
      drive_start_s)
    else $error("continuous start not driven by device");
  quiet_wait_a: assert property (state_reg == ST_IDLE && !POLL_SELECT && SIO_IN |=>
      state_reg == ST_IDLE && !SIO_OE)
    else $error("quiet mode started on its own");
  mode_take_a: assert property ($rose(state_reg == ST_FRAME) |->
      mode_reg == $past(POLL_SELECT))
    else $error("stop width not taken at start end");
  hold_wait_a: assert property (hold_reg && state_reg == ST_GAP && !CYCLE_HOLD_N |=>
      state_reg != ST_START)
    else $error("start begun while hold low");
  reset_float_a: assert property (@(posedge CORE_CLK) disable iff (RST) !DEVICE_RESET_N |=>
      !SIO_OE && !BUSY_OE && INT_OE == 21'h000000)
    else $error("outputs driven during device reset");
  shut_float_a: assert property (@(posedge CORE_CLK) disable iff (RST) !SHUTDOWN_N |=>
      !SIO_OE && !BUSY_OE && INT_OE == 21'h000000)
    else $error("outputs driven during shutdown");

endmodule : sird_top

/* dv/sird_card_model.sv */
// Purpose: Far-end card controller model on the shared serial interrupt line
// Assumes: Line has a pull-up; model only ever pulls low
// Notes:   Frame slots tracked by counting eight low clocks of a start frame
`timescale 1ns/1ps
module sird_card_model
  import sird_pkg::*;
(
  input  wire logic        clk,        // Core clock
  input  wire logic        rst,        // Async reset, active high
  input  wire logic        line,       // Resolved line level
  input  wire logic        kick,       // Quiet mode start request
  input  wire logic [20:0] pattern,    // Slots to pull low next cycle
  output logic             pull_low,   // Model pulls the line low
  output logic             sample_low  // Low driven in a sample phase
);
  logic [4:0]  low_run_reg;
  logic [4:0]  slot_reg;
  logic [1:0]  phase_reg;
  logic        active_reg;
  logic [20:0] pat_reg;
  // Start seen anywhere, so any idle count before it is fine
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      low_run_reg <= 5'h00;
      slot_reg    <= 5'h00;
      phase_reg   <= 2'h0;
      active_reg  <= 1'b0;
      pat_reg     <= 21'h000000;
    end
    else
    begin
      low_run_reg <= line ? 5'h00 : low_run_reg + 5'h01;
      if (!line && low_run_reg == START_CLKS - 5'h01)
      begin
        active_reg <= 1'b1;
        slot_reg   <= 5'h00;
        phase_reg  <= 2'h0;
        pat_reg    <= pattern;
      end
      else if (active_reg)
      begin
        phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
        if (phase_reg == 2'h2)
        begin
          slot_reg <= slot_reg + 5'h01;
          if (slot_reg == FRAME_COUNT - 5'h01)
            active_reg <= 1'b0;
        end
      end
    end
  end
  // Pull low only in a sample phase, or one clock to open a quiet cycle
  assign sample_low = active_reg && phase_reg == 2'h0 && pat_reg[slot_reg];
  assign pull_low   = sample_low || kick;
endmodule : sird_card_model

/* dv/tb_sird_top.sv */
// Purpose: Self-checking bench for the serial interrupt deserializer
// Assumes: Line resolved here with a pull-up; card model on far side
// Notes:   Observation on falling edges, stimulus on rising edges
`timescale 1ns/1ps
module tb_sird_top;
  import sird_pkg::*;
  logic        core_clk, rst, device_reset_n, shutdown_n, poll_select, rds, hold_n, kick;
  logic        sio_out, sio_oe, busy, busy_oe, pull_low, sample_low, sl_d, rd, wr;
  logic [20:0] int_oe, pattern;
  logic [1:0]  addr;
  logic [31:0] wdata, rdata, seed, rv;
  int          fail_count, checked, len, gap, cnt;
  wire         dev_low = sio_oe && !sio_out;
  wire         line    = (dev_low || pull_low) ? 1'b0 : 1'b1;

  sird_top sird_top_inst (.CORE_CLK(core_clk), .RST(rst), .DEVICE_RESET_N(device_reset_n),
    .SHUTDOWN_N(shutdown_n), .POLL_SELECT(poll_select), .RECOVERY_DRIVE_SELECT(rds),
    .CYCLE_HOLD_N(hold_n), .SIO_IN(line), .SIO_OUT(sio_out), .SIO_OE(sio_oe), .INT_OE(int_oe),
    .BUSY(busy), .BUSY_OE(busy_oe), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata));
  sird_card_model sird_card_model_inst (.clk(core_clk), .rst(rst), .line(line), .kick(kick),
    .pattern(pattern), .pull_low(pull_low), .sample_low(sample_low));

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr_next
  function automatic logic [31:0] exp_stop(input logic cont);
    return cont ? 32'(STOP_CONT) : 32'(STOP_QUIET);
  endfunction : exp_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // Gap before and length of the next device-driven low run
  task automatic next_run(output int l, output int g);
    l = 0;
    g = 0;
    while (!dev_low && g < 3000)
    begin
      @(negedge core_clk);
      g++;
    end
    while (dev_low && l < 40)
    begin
      @(negedge core_clk);
      l++;
    end
  endtask : next_run
  task automatic reg_access(input logic w, input logic [1:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge core_clk);
    q = rdata;
  endtask : reg_access

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Watchdog sized well past the whole sequence
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    tally_and_finish();
  end
  // Recovery after a sampled low follows the drive select; looked at mid-cycle
  always @(negedge core_clk)
  begin
    if (sl_d && shutdown_n)
      check(32'({sio_oe, sio_oe & sio_out}), 32'({rds, rds}));
    sl_d <= sample_low;
  end

  initial
  begin
    {rst, device_reset_n, shutdown_n, poll_select, hold_n} = 5'h1F;
    {rds, kick, rd, wr, sl_d} = 5'h00;
    addr = 2'h0;
    wdata = 32'h0;
    seed = 32'hCBA472C5;
    pattern = seed[20:0];
    fail_count = 0;
    checked = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      next_run(len, gap);
      if (i > 0)
        check(32'(gap), 32'(GAP_CONT));
      check(32'(len), 32'(START_CLKS));
      if (i == 3)
      begin
        // Register traffic runs beside the frame count, not in its way
        fork
          begin
            @(posedge core_clk);
            hold_n <= 1'b0;
            reg_access(1'b1, ADDR_CTRL, 32'h1, rv);
            reg_access(1'b0, ADDR_CTRL, 32'h0, rv);
            check(rv, 32'h1);
            reg_access(1'b0, 2'h3, 32'h0, rv);
            check(rv, 32'h0);
            reg_access(1'b1, ADDR_CTRL, 32'h0, rv);
          end
        join_none
      end
      next_run(len, gap);
      check(32'(gap), 32'(FRAME_COUNT) * 32'(FRAME_PHASES));
      check(32'(len), exp_stop(1'b1));
      check(32'(int_oe), 32'(pattern));
      @(posedge core_clk);
      seed = lfsr_next(seed);
      pattern <= (i == 1) ? 21'h1FFFFF : seed[20:0];
      rds <= seed[21];
    end
    // Hold stays low 30 clocks past the stop
    fork
      begin
        repeat (30) @(posedge core_clk);
        hold_n <= 1'b1;
      end
    join_none
    next_run(len, gap);
    check(32'(gap > 30 && gap < 50), 32'h1);
    @(posedge core_clk);
    poll_select <= 1'b0;
    @(negedge core_clk);
    next_run(len, gap);
    check(32'(len), exp_stop(1'b1));
    check(32'(int_oe), 32'(pattern));
    cnt = 0;
    repeat (60)
    begin
      @(negedge core_clk);
      cnt += int'(dev_low);
    end
    check(32'(cnt), 32'h0);
    reg_access(1'b0, ADDR_FRAMES, 32'h0, rv);
    check(rv, 32'(pattern));
    reg_access(1'b0, ADDR_STATUS, 32'h0, rv);
    check(rv, {25'h0000000, 1'b0, 1'b1, 1'b1, ST_IDLE, 1'b0});
    @(posedge core_clk);
    kick <= 1'b1;
    @(negedge core_clk);
    check(32'(busy), 32'h1);
    @(posedge core_clk);
    kick <= 1'b0;
    @(negedge core_clk);
    check(32'(busy), 32'h0);
    next_run(len, gap);
    check(32'(len + 1), 32'(START_CLKS));
    next_run(len, gap);
    check(32'(len), exp_stop(1'b0));
    check(32'(busy), 32'h0);
    repeat (2) @(negedge core_clk);
    check(32'(busy), 32'h1);
    @(posedge core_clk);
    device_reset_n <= 1'b0;
    poll_select <= 1'b1;
    repeat (2) @(negedge core_clk);
    check(32'({sio_oe, busy_oe, int_oe}), 32'h0);
    @(posedge core_clk);
    device_reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    poll_select <= 1'b0;
    @(negedge core_clk);
    check(32'(dev_low), 32'h1);
    next_run(len, gap);
    next_run(len, gap);
    check(32'(len), exp_stop(1'b0));
    @(posedge core_clk);
    shutdown_n <= 1'b0;
    repeat (2) @(negedge core_clk);
    check(32'({sio_oe, busy_oe, int_oe}), 32'h0);
    @(posedge core_clk);
    shutdown_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    tally_and_finish();
  end
endmodule : tb_sird_top
